// file: i2c_master_controller.sv
// two-wire bus master reached through special function registers
// assumes sfr strobes on the system clock; pin levels are asynchronous
`timescale 1ns/1ns
module i2c_master_controller (
  input  wire logic       CLK_SYS_I,
  input  wire logic       RESETN_I,
  input  wire logic [7:0] SFR_ADDR_I,
  input  wire logic       SFR_WR_I,
  input  wire logic       SFR_RD_I,
  input  wire logic [7:0] SFR_WDATA_I,
  output logic      [7:0] SFR_RDATA_O,
  output logic            IRQ_O,
  input  wire logic [1:0] P1_MODE3_I,
  input  wire logic [1:0] P1_MODE6_I,
  input  wire logic [1:0] P3_MODE5_I,
  input  wire logic       P0_OE2_I,
  input  wire logic       P16_DATA_I,
  input  wire logic       P35_DATA_I,
  input  wire logic       P35_SDA_I,
  input  wire logic       P16_SDA_I,
  output logic            P35_SDA_O,
  output logic            P35_SDA_OE_O,
  output logic            P16_SDA_O,
  output logic            P16_SDA_OE_O,
  output logic            P13_SCL_O,
  output logic            P13_SCL_OE_O,
  output logic            P02_SCL_O,
  output logic            P02_SCL_OE_O
);
  import i2cm_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [7:0] ie1;
    logic [7:0] psel;
    logic       en;
    logic       acko;
    logic       flag;
    logic       acki;
    logic       start;
    logic       stop;
    logic [1:0] div;
    logic [7:0] dat;
    logic [7:0] rdata;
    logic       irq;
    eng_st_t    st;
    logic [1:0] ph;
    logic [2:0] bits;
    logic [7:0] sh;
    logic       rxm;
    logic       dir;
    logic       addr;
    logic       scl;
    logic       sda;
    logic       sda_m;
    logic       sda_s;
    logic       start_d;
    logic       push;
    logic [7:0] pins;
  } top_state_t;

  top_state_t s_ff, nxt_s;

  logic       tick;
  logic       in_ready;
  logic       out_valid;
  logic       out_ready;
  logic [7:0] out_data;
  logic       wr_ctl;
  logic       wr_dat;
  logic       rd_dat;

  function automatic logic [7:0] reg_read(input top_state_t s, input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      ADR_IE1:  v = s.ie1 & IE1_MASK;
      ADR_PSEL: v = s.psel;
      ADR_CTL:  v = {s.en, s.acko, s.flag, s.acki, s.start, s.stop, s.div};
      ADR_DAT:  v = s.dat;
      default:  v = 8'h00;
    endcase
    return v;
  endfunction

  // ****************************************
  // sub blocks
  // ****************************************
  i2cm_qtr_div u_div (
    .clk_i   (CLK_SYS_I),
    .rst_n_i (RESETN_I),
    .run_i   (s_ff.en),
    .sel_i   (s_ff.div),
    .tick_o  (tick)
  );

  // received bytes wait here until software has taken the previous one
  assign out_ready = !s_ff.flag;

  i2cm_buf2 #(
    .W (8)
  ) u_rxbuf (
    .clk_i       (CLK_SYS_I),
    .rst_n_i     (RESETN_I),
    .in_valid_i  (s_ff.push),
    .in_ready_o  (in_ready),
    .in_data_i   (s_ff.sh),
    .out_valid_o (out_valid),
    .out_ready_i (out_ready),
    .out_data_o  (out_data)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    nxt_s  = s_ff;
    wr_ctl = SFR_WR_I && (SFR_ADDR_I == ADR_CTL);
    wr_dat = SFR_WR_I && (SFR_ADDR_I == ADR_DAT);
    rd_dat = SFR_RD_I && (SFR_ADDR_I == ADR_DAT);

    // input synchroniser for the selected data pin
    nxt_s.sda_m = s_ff.psel[B_SDASEL] ? P16_SDA_I : P35_SDA_I;
    nxt_s.sda_s = s_ff.sda_m;
    nxt_s.start_d = s_ff.start;

    // register writes
    if (SFR_WR_I && (SFR_ADDR_I == ADR_IE1)) begin
      nxt_s.ie1 = SFR_WDATA_I & IE1_MASK;
    end
    if (SFR_WR_I && (SFR_ADDR_I == ADR_PSEL)) begin
      nxt_s.psel = SFR_WDATA_I;
    end
    if (wr_ctl) begin
      nxt_s.en    = SFR_WDATA_I[B_EN];
      nxt_s.acko  = SFR_WDATA_I[B_ACKO];
      nxt_s.start = SFR_WDATA_I[B_START];
      nxt_s.stop  = SFR_WDATA_I[B_STOP];
      nxt_s.div   = SFR_WDATA_I[B_DIV+1:B_DIV];
      if (!SFR_WDATA_I[B_FLAG]) begin
        nxt_s.flag = 1'b0;
      end
    end
    if (wr_dat) begin
      nxt_s.dat = SFR_WDATA_I;
    end
    if (SFR_RD_I) begin
      nxt_s.rdata = reg_read(s_ff, SFR_ADDR_I);
    end

    // a received byte moves into the data register and raises the flag
    if (out_valid && out_ready) begin
      nxt_s.dat  = out_data;
      nxt_s.flag = 1'b1;
    end
    nxt_s.push = s_ff.push && !in_ready;

    // ****************************************
    // bus engine
    // ****************************************
    if (!s_ff.en) begin
      nxt_s.st   = ST_IDLE;
      nxt_s.scl  = 1'b1;
      nxt_s.sda  = 1'b1;
      nxt_s.ph   = 2'h0;
      nxt_s.push = 1'b0;
    end else begin
      unique case (s_ff.st)
        ST_IDLE: begin
          nxt_s.scl = 1'b1;
          nxt_s.sda = 1'b1;
          nxt_s.ph  = 2'h0;
          if (s_ff.start && !s_ff.start_d) begin
            nxt_s.st   = ST_START;
            nxt_s.sh   = s_ff.dat;
            nxt_s.dir  = s_ff.dat[0];
            nxt_s.addr = 1'b1;
            nxt_s.rxm  = 1'b0;
          end
        end
        ST_START: begin
          if (tick) begin
            nxt_s.ph = s_ff.ph + 2'h1;
            if (s_ff.ph == 2'h1) begin
              nxt_s.sda = 1'b0;
            end
            if (s_ff.ph == 2'h2) begin
              nxt_s.scl  = 1'b0;
              nxt_s.st   = ST_BITS;
              nxt_s.ph   = 2'h0;
              nxt_s.bits = BIT_LAST;
            end
          end
        end
        ST_BITS: begin
          if (tick) begin
            nxt_s.ph = s_ff.ph + 2'h1;
            unique case (s_ff.ph)
              2'h0: nxt_s.sda = s_ff.rxm ? 1'b1 : s_ff.sh[7];
              2'h1: nxt_s.scl = 1'b1;
              2'h2: nxt_s.scl = 1'b1;
              default: begin
                // sample late: the synchroniser trails the line by two cycles
                nxt_s.sh  = {s_ff.sh[6:0], s_ff.sda_s};
                nxt_s.scl = 1'b0;
                if (s_ff.bits == 3'h0) begin
                  nxt_s.st = ST_ACK;
                end else begin
                  nxt_s.bits = s_ff.bits - 3'h1;
                end
              end
            endcase
          end
        end
        ST_ACK: begin
          if (tick) begin
            nxt_s.ph = s_ff.ph + 2'h1;
            unique case (s_ff.ph)
              2'h0: nxt_s.sda = s_ff.rxm ? s_ff.acko : 1'b1;
              2'h1: nxt_s.scl = 1'b1;
              2'h2: nxt_s.scl = 1'b1;
              default: begin
                if (!s_ff.rxm) begin
                  nxt_s.acki = s_ff.sda_s;
                end
                nxt_s.scl  = 1'b0;
                nxt_s.addr = 1'b0;
                if (s_ff.rxm) begin
                  nxt_s.push = 1'b1;
                  nxt_s.st   = ST_PUSH;
                end else begin
                  nxt_s.flag = 1'b1;
                  nxt_s.st   = ST_HOLD;
                  if (s_ff.addr) begin
                    nxt_s.rxm = s_ff.dir;
                  end
                end
              end
            endcase
          end
        end
        ST_PUSH: begin
          // engine stalls until the buffer has taken the byte
          if (!s_ff.push) begin
            nxt_s.st = ST_HOLD;
          end
        end
        ST_HOLD: begin
          nxt_s.ph = 2'h0;
          if (tick && s_ff.ph == 2'h0) begin
            nxt_s.sda = 1'b1;
          end
          if (s_ff.stop) begin
            nxt_s.st  = ST_STOP;
            nxt_s.sda = 1'b0;
          end else if (wr_dat && !s_ff.rxm) begin
            nxt_s.sh   = SFR_WDATA_I;
            nxt_s.st   = ST_BITS;
            nxt_s.bits = BIT_LAST;
          end else if (rd_dat && s_ff.rxm) begin
            nxt_s.st   = ST_BITS;
            nxt_s.bits = BIT_LAST;
          end
        end
        ST_STOP: begin
          if (tick) begin
            nxt_s.ph = s_ff.ph + 2'h1;
            unique case (s_ff.ph)
              2'h0: nxt_s.sda = 1'b0;
              2'h1: nxt_s.scl = 1'b1;
              2'h2: nxt_s.sda = 1'b1;
              default: nxt_s.st = ST_IDLE;
            endcase
          end
        end
        default: nxt_s.st = ST_IDLE;
      endcase
    end

    // interrupt request
    nxt_s.irq = nxt_s.flag && nxt_s.ie1[B_IRQEN];

    // ****************************************
    // pin drive
    // ****************************************
    nxt_s.pins = 8'h00;
    if (s_ff.en) begin
      if (s_ff.psel[B_SCLSEL]) begin
        // port 0 clock pin
        nxt_s.pins[1] = P0_OE2_I ? s_ff.scl : 1'b0;
        nxt_s.pins[0] = P0_OE2_I ? 1'b1 : !s_ff.scl;
      end else if (P1_MODE3_I == PIN_MODE_PP) begin
        nxt_s.pins[3] = s_ff.scl;
        nxt_s.pins[2] = 1'b1;
      end else if (P1_MODE3_I == PIN_MODE_OD) begin
        nxt_s.pins[3] = 1'b0;
        nxt_s.pins[2] = !s_ff.scl;
      end
      if (s_ff.psel[B_SDASEL]) begin
        if (P1_MODE6_I == PIN_MODE_OD && P16_DATA_I) begin
          nxt_s.pins[4] = !s_ff.sda;
        end
      end else if (P3_MODE5_I == PIN_MODE_OD && P35_DATA_I) begin
        nxt_s.pins[6] = !s_ff.sda;
      end
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      s_ff       <= '0;
      s_ff.ie1   <= RST_IE1;
      s_ff.psel  <= RST_PSEL;
      s_ff.stop  <= RST_CTL[B_STOP];
      s_ff.dat   <= RST_DAT;
      s_ff.st    <= ST_IDLE;
      s_ff.scl   <= 1'b1;
      s_ff.sda   <= 1'b1;
      s_ff.sda_m <= 1'b1;
      s_ff.sda_s <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign SFR_RDATA_O  = s_ff.rdata;
  assign IRQ_O        = s_ff.irq;
  assign P02_SCL_OE_O = s_ff.pins[0];
  assign P02_SCL_O    = s_ff.pins[1];
  assign P13_SCL_OE_O = s_ff.pins[2];
  assign P13_SCL_O    = s_ff.pins[3];
  assign P16_SDA_OE_O = s_ff.pins[4];
  assign P16_SDA_O    = s_ff.pins[5];
  assign P35_SDA_OE_O = s_ff.pins[6];
  assign P35_SDA_O    = s_ff.pins[7];
endmodule

// file: i2cm_pkg.sv
// constants, register map and engine states of the two-wire bus master
// assumes an 8-bit special function register bus and 25 MHz system clock
package i2cm_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] ADR_IE1  = 8'ha9;
  localparam logic [7:0] ADR_PSEL = 8'hb7;
  localparam logic [7:0] ADR_CTL  = 8'he1;
  localparam logic [7:0] ADR_DAT  = 8'he2;

  // ****************************************
  // field positions
  // ****************************************
  localparam int B_IRQEN  = 4;
  localparam int B_SDASEL = 7;
  localparam int B_SCLSEL = 6;
  localparam int B_EN     = 7;
  localparam int B_ACKO   = 6;
  localparam int B_FLAG   = 5;
  localparam int B_ACKI   = 4;
  localparam int B_START  = 3;
  localparam int B_STOP   = 2;
  localparam int B_DIV    = 0;

  // ****************************************
  // reset values and masks
  // ****************************************
  localparam logic [7:0] RST_IE1  = 8'h00;
  localparam logic [7:0] RST_PSEL = 8'h00;
  localparam logic [7:0] RST_CTL  = 8'h04;
  localparam logic [7:0] RST_DAT  = 8'h00;
  localparam logic [7:0] IE1_MASK = 8'hbf;

  // ****************************************
  // pin modes and divider codes
  // ****************************************
  localparam logic [1:0] PIN_MODE_OD = 2'h0;
  localparam logic [1:0] PIN_MODE_PP = 2'h2;
  localparam logic [1:0] DIV_SEL_4   = 2'h0;
  localparam logic [1:0] DIV_SEL_16  = 2'h1;
  localparam logic [1:0] DIV_SEL_64  = 2'h2;
  localparam logic [5:0] QTR_RLD_4   = 6'h00;
  localparam logic [5:0] QTR_RLD_16  = 6'h03;
  localparam logic [5:0] QTR_RLD_64  = 6'h0f;
  localparam logic [5:0] QTR_RLD_256 = 6'h3f;
  localparam logic [2:0] BIT_LAST    = 3'h7;
  localparam logic [1:0] PH_LAST     = 2'h3;

  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_START = 7'h02,
    ST_BITS  = 7'h04,
    ST_ACK   = 7'h08,
    ST_PUSH  = 7'h10,
    ST_HOLD  = 7'h20,
    ST_STOP  = 7'h40
  } eng_st_t;

endpackage

// file: i2cm_qtr_div.sv
// quarter bit tick generator for the bus clock
// assumes the select code comes from a register on the same clock
`timescale 1ns/1ns
module i2cm_qtr_div (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       run_i,
  input  wire logic [1:0] sel_i,
  output logic            tick_o
);
  import i2cm_pkg::*;

  typedef struct packed {
    logic [5:0] cnt;
    logic       tick;
  } div_state_t;

  div_state_t s_ff, nxt_s;
  logic [5:0] rld;

  // four ticks per bus clock period
  always_comb begin
    unique case (sel_i)
      DIV_SEL_4:  rld = QTR_RLD_4;
      DIV_SEL_16: rld = QTR_RLD_16;
      DIV_SEL_64: rld = QTR_RLD_64;
      default:    rld = QTR_RLD_256;
    endcase
    nxt_s = s_ff;
    nxt_s.tick = 1'b0;
    if (!run_i) begin
      nxt_s.cnt = rld;
    end else if (s_ff.cnt == 6'h00) begin
      nxt_s.cnt  = rld;
      nxt_s.tick = 1'b1;
    end else begin
      nxt_s.cnt = s_ff.cnt - 6'h01;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign tick_o = s_ff.tick;
endmodule

// file: i2cm_buf2.sv
// two-entry buffer with valid and ready on both sides
// assumes both sides run on the same clock
`timescale 1ns/1ns
module i2cm_buf2 #(
  parameter int W = 8
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  typedef struct packed {
    logic [1:0][W-1:0] ent;
    logic [1:0]        cnt;
  } buf_state_t;

  buf_state_t s_ff, nxt_s;
  logic       push;
  logic       pop;

  always_comb begin
    push  = in_valid_i && (s_ff.cnt != 2'h2);
    pop   = out_ready_i && (s_ff.cnt != 2'h0);
    nxt_s = s_ff;
    if (pop) begin
      nxt_s.ent[0] = s_ff.ent[1];
    end
    if (push) begin
      nxt_s.ent[(pop ? s_ff.cnt - 2'h1 : s_ff.cnt) != 2'h0] = in_data_i;
    end
    nxt_s.cnt = s_ff.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign in_ready_o  = s_ff.cnt != 2'h2;
  assign out_valid_o = s_ff.cnt != 2'h0;
  assign out_data_o  = s_ff.ent[0];
endmodule

// file: i2c_master_controller_asserts.sv
// checker for the two-wire bus master: pin routing, bus framing, interrupt
// assumes the bench feeds the resolved data line to the data pin inputs
`timescale 1ns/1ns
module i2c_master_controller_chk
  import i2cm_pkg::*;
(
  input wire logic       CLK_SYS_I,
  input wire logic       RESETN_I,
  input wire logic [7:0] SFR_ADDR_I,
  input wire logic       SFR_WR_I,
  input wire logic [7:0] SFR_WDATA_I,
  input wire logic       IRQ_O,
  input wire logic [1:0] P1_MODE3_I,
  input wire logic       P0_OE2_I,
  input wire logic       P35_SDA_I,
  input wire logic       P35_SDA_OE_O,
  input wire logic       P16_SDA_OE_O,
  input wire logic       P13_SCL_O,
  input wire logic       P13_SCL_OE_O,
  input wire logic       P02_SCL_O,
  input wire logic       P02_SCL_OE_O
);
  // ****************************************
  // register shadows and line levels
  // ****************************************
  logic [7:0] ctl_ff, psel_ff, ie_ff;
  logic       scl, sda;
  assign scl = (P13_SCL_OE_O ? P13_SCL_O : 1'b1) & (P02_SCL_OE_O ? P02_SCL_O : 1'b1);
  assign sda = P35_SDA_I;
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      {ctl_ff, psel_ff, ie_ff} <= {RST_CTL, RST_PSEL, RST_IE1};
    end else if (SFR_WR_I) begin
      if (SFR_ADDR_I == ADR_CTL) ctl_ff <= SFR_WDATA_I;
      if (SFR_ADDR_I == ADR_PSEL) psel_ff <= SFR_WDATA_I;
      if (SFR_ADDR_I == ADR_IE1) ie_ff <= SFR_WDATA_I;
    end
  end
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESETN_I);
  sequence s_scl_up; $rose(scl); endsequence
  sequence s_high_2; scl [*2]; endsequence
  sequence s_high_8; scl [*8]; endsequence
  a_off_pins_idle: assert property ((!ctl_ff[B_EN]) [*2] |->
    !(P35_SDA_OE_O || P16_SDA_OE_O || P13_SCL_OE_O || P02_SCL_OE_O)) else $error("pin driven");
  a_sda_pin_sel: assert property ((!psel_ff[B_SDASEL]) [*2] |-> !P16_SDA_OE_O)
    else $error("data on wrong pin");
  a_scl_pin_sel: assert property ((psel_ff[B_SCLSEL]) [*2] |-> !P13_SCL_OE_O)
    else $error("clock on wrong pin");
  a_od_clock_p13: assert property ((P1_MODE3_I == PIN_MODE_OD) [*2] |->
    !(P13_SCL_OE_O && P13_SCL_O)) else $error("clock driven high in open drain");
  a_od_clock_p02: assert property ((!P0_OE2_I) [*2] |-> !(P02_SCL_OE_O && P02_SCL_O))
    else $error("port0 clock driven high");
  a_irq_needs_ie: assert property (IRQ_O |-> ie_ff[B_IRQEN])
    else $error("interrupt while disabled");
  a_irq_holds: assert property (IRQ_O && !SFR_WR_I |=> IRQ_O)
    else $error("flag dropped without clear");
  a_start_needs_bit: assert property ($fell(sda) && scl && $past(scl) |->
    ctl_ff[B_EN] && ctl_ff[B_START]) else $error("start without start bit");
  a_stop_needs_bit: assert property ($rose(sda) && scl && $past(scl) |->
    ctl_ff[B_STOP] || !ctl_ff[B_EN]) else $error("stop without stop bit");
  a_scl_high_fast: assert property (s_scl_up ##0 ctl_ff[1:0] == DIV_SEL_4 |-> s_high_2)
    else $error("clock high too short");
  a_scl_high_mid: assert property (s_scl_up ##0 ctl_ff[1:0] == DIV_SEL_16 |-> s_high_8)
    else $error("clock high too short");
endmodule
bind i2c_master_controller i2c_master_controller_chk i_chk (.*);

// file: i2cm_slave_model.sv
// two-wire bus slave model: acks written bytes, returns one byte on reads
// assumes the bench resolves both lines with pull-ups
`timescale 1ns/1ns
module i2cm_slave_model (
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic       nack_i,
  input  wire logic [7:0] tx_i,
  output logic            pull_o,
  output logic [7:0]      rx_o,
  output logic            mack_o
);
  // ****************************************
  // framing and bit handling
  // ****************************************
  int         b = 0;
  logic       act = 1'b0;
  logic       adr = 1'b0;
  logic       snd = 1'b0;
  logic [7:0] sh = 8'h00;
  initial pull_o = 1'b0;
  initial mack_o = 1'b0;
  always @(negedge sda_i) if (scl_i) begin
    {act, adr, snd, pull_o} = 4'b1100;
    // the clock fall that ends the start condition is not a bit
    b = -1;
  end
  always @(posedge sda_i) if (scl_i) begin
    act = 1'b0;
    pull_o = 1'b0;
  end
  always @(posedge scl_i) if (act) begin
    if (b < 8 && !snd) sh = {sh[6:0], sda_i};
    if (b == 8 && snd) mack_o = sda_i;
  end
  always @(negedge scl_i) if (act) begin
    if (b == 8) begin
      b = 0;
      pull_o = 1'b0;
      if (snd && mack_o) act = 1'b0;
      if (adr) snd = sh[0];
      if (adr) mack_o = 1'b0;
      adr = 1'b0;
      if (snd && !mack_o && act) pull_o = !tx_i[7];
    end else begin
      b++;
      if (b == 8) rx_o = sh;
      pull_o = (b == 8) ? (!snd && !nack_i) : (snd && !tx_i[7 - b]);
    end
  end
endmodule

// file: tb_i2c_master_controller.sv
// bench for the two-wire bus master: random write and read transfers
// assumes the checker and slave model are compiled before it
`timescale 1ns/1ns
module tb_i2c_master_controller;
  import i2cm_pkg::*;
  // ****************************************
  // wiring, clock and bus tasks
  // ****************************************
  logic       clk, rst_n, wr_s, rd_s, irq, p0_oe, nack, mack, pull;
  logic       s35, s35_oe, s16, s16_oe, c13, c13_oe, c02, c02_oe, sda, scl;
  logic [1:0] p13_mode;
  logic [7:0] addr, wdata, rdata, rd_q, tx_byte, rx_byte;
  int         n_mismatch = 0;
  int         compares = 0;
  int         cyc = 0;
  assign scl = (c13_oe ? c13 : 1'b1) & (c02_oe ? c02 : 1'b1);
  assign sda = (s35_oe ? s35 : 1'b1) & (s16_oe ? s16 : 1'b1) & !pull;
  i2c_master_controller i_dut (
    .CLK_SYS_I(clk), .RESETN_I(rst_n), .SFR_ADDR_I(addr), .SFR_WR_I(wr_s),
    .SFR_RD_I(rd_s), .SFR_WDATA_I(wdata), .SFR_RDATA_O(rdata), .IRQ_O(irq),
    .P1_MODE3_I(p13_mode), .P1_MODE6_I(PIN_MODE_OD), .P3_MODE5_I(PIN_MODE_OD),
    .P0_OE2_I(p0_oe), .P16_DATA_I(1'b1), .P35_DATA_I(1'b1), .P35_SDA_I(sda),
    .P16_SDA_I(sda), .P35_SDA_O(s35), .P35_SDA_OE_O(s35_oe), .P16_SDA_O(s16),
    .P16_SDA_OE_O(s16_oe), .P13_SCL_O(c13), .P13_SCL_OE_O(c13_oe), .P02_SCL_O(c02),
    .P02_SCL_OE_O(c02_oe));
  i2cm_slave_model i_slave (.scl_i(scl), .sda_i(sda), .nack_i(nack), .tx_i(tx_byte),
    .pull_o(pull), .rx_o(rx_byte), .mack_o(mack));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one register access, strobe for one cycle, read data taken after
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    {addr, wdata, wr_s, rd_s} = {a, d, w, !w};
    @(negedge clk);
    {wr_s, rd_s} = 2'b00;
    @(negedge clk);
    rd_q = rdata;
  endtask
  task automatic wait_done();
    rd_q = 8'h00;
    for (int k = 0; k < 3000 && rd_q[B_FLAG] !== 1'b1; k++) bus(0, ADR_CTL, 8'h00);
  endtask
  task automatic txn(input logic rx, input logic [1:0] div);
    logic [7:0] a, d, c;
    logic       nk, ak, ie;
    a = 8'($urandom);
    d = 8'($urandom);
    {nk, ak, ie} = 3'($urandom);
    a[0] = rx;
    if (!ak) d[7] = 1'b1;
    c = {1'b1, ak, 3'b001, 1'b0, div};
    {tx_byte, nack, p0_oe} = {d, 1'b0, 1'($urandom)};
    p13_mode = $urandom_range(1) ? PIN_MODE_PP : PIN_MODE_OD;
    bus(1, ADR_PSEL, {2'($urandom), 6'h00});
    bus(1, ADR_IE1, {3'h0, ie, 4'h0});
    bus(1, ADR_DAT, a);
    bus(1, ADR_CTL, c);
    wait_done();
    chk(rx_byte, a);
    chk(8'(irq), 8'(ie));
    bus(1, ADR_CTL, c | 8'h30);
    bus(0, ADR_CTL, 8'h00);
    chk(rd_q, c | 8'h20);
    bus(1, ADR_CTL, c);
    if (rx) begin
      bus(0, ADR_DAT, 8'h00);
      wait_done();
    end else begin
      nack = nk;
      bus(1, ADR_DAT, d);
      wait_done();
      chk(rd_q, c | 8'h20 | {3'h0, nk, 4'h0});
      chk(rx_byte, d);
    end
    bus(1, ADR_CTL, (c & 8'hf7) | 8'h04);
    bus(0, ADR_DAT, 8'h00);
    if (rx) chk(rd_q, d);
    if (rx) chk(8'(mack), 8'(ak));
    repeat (600) @(negedge clk);
    chk(8'({scl, sda}), 8'h03);
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(32'h84f859f2));
    {wr_s, rd_s, p0_oe, nack, addr, wdata, tx_byte} = '0;
    p13_mode = PIN_MODE_OD;
    rst_n = 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    bus(0, ADR_CTL, 8'h00);
    chk(rd_q, RST_CTL);
    bus(0, ADR_PSEL, 8'h00);
    chk(rd_q, RST_PSEL);
    bus(0, ADR_DAT, 8'h00);
    chk(rd_q, RST_DAT);
    bus(1, ADR_IE1, 8'hff);
    bus(0, ADR_IE1, 8'h00);
    chk(rd_q, IE1_MASK);
    bus(1, 8'h00, 8'hff);
    bus(0, 8'h00, 8'h00);
    chk(rd_q, 8'h00);
    for (int i = 0; i < 8; i++) txn(i[0], 2'(i >> 1));
    bus(1, ADR_DAT, 8'h50);
    bus(1, ADR_CTL, 8'h88);
    repeat (6) @(negedge clk);
    bus(1, ADR_CTL, RST_CTL);
    chk(8'({s35_oe, s16_oe, c13_oe, c02_oe}), 8'h00);
    tally_and_finish();
  end
endmodule
